// [frpcfg_top.sv]
// Purpose: APB register bank steering frame reference generator and phase sync delay
// Assumes: CLK_I at 20 MHz; sync and request pins are asynchronous
// Notes:   One wait-free access phase; PRDATA registered in the setup cycle
`include "frpcfg_params.svh"

module frpcfg_top #(
	parameter int NREG = 12
)
(
	input  wire logic        CLK_I,
	input  wire logic        SRST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [15:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	input  wire logic        FRAME_REF_REQUEST_PIN_I,
	input  wire logic        SYNC_PIN_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic             FRAME_REF_O,
	output logic             MOD_RESET_O,
	output logic             PHASE_SYNC_DONE_O
);

	// ==========================================
	// Register slots
	localparam logic [3:0] S_DLY_HI    = 4'h5;
	localparam logic [3:0] S_DLY_LO    = 4'h6;
	localparam logic [3:0] S_CTRL      = 4'h7;
	localparam logic [3:0] S_OUT_DIV   = 4'h8;
	localparam logic [3:0] S_PULSE_CNT = 4'h9;
	localparam logic [3:0] S_PIN_MASK  = 4'hA;
	localparam logic [3:0] S_SYNC_CTRL = 4'hB;

	localparam logic [7:0] SLOT_IDX [NREG] = '{
		`FRPCFG_IDX_RSV_A, `FRPCFG_IDX_RSV_B, `FRPCFG_IDX_RSV_C,
		`FRPCFG_IDX_RSV_D, `FRPCFG_IDX_RSV_E, `FRPCFG_IDX_DLY_HI,
		`FRPCFG_IDX_DLY_LO, `FRPCFG_IDX_CTRL, `FRPCFG_IDX_OUT_DIV,
		`FRPCFG_IDX_PULSE_CNT, `FRPCFG_IDX_PIN_MASK, `FRPCFG_IDX_SYNC_CTRL
	};

	localparam logic [15:0] SLOT_RST [NREG] = '{
		`FRPCFG_RST_RSV_A, // [R01]
		`FRPCFG_RST_RSV_B,
		`FRPCFG_RST_RSV_C, // [R03]
		`FRPCFG_RST_RSV_D,
		`FRPCFG_RST_RSV_E, // [R04]
		`FRPCFG_RST_DLY_HI, // [R05]
		`FRPCFG_RST_DLY_LO, // [R06]
		`FRPCFG_RST_CTRL, // [R09]
		`FRPCFG_RST_OUT_DIV, // [R13]
		`FRPCFG_RST_PULSE_CNT,
		`FRPCFG_RST_PIN_MASK, // [R15]
		`FRPCFG_RST_SYNC_CTRL
	};

	// ==========================================
	// Declarations
	logic [15:0] regs_ff [NREG];
	logic [15:0] nxt_regs [NREG];
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic        pready_ff;
	logic        nxt_pready;
	logic        pslverr_ff;
	logic        nxt_pslverr;
	logic        req_s1_ff;
	logic        req_s2_ff;
	logic        req_s3_ff;
	logic        sync_s1_ff;
	logic        sync_s2_ff;
	logic        sync_s3_ff;
	logic        nxt_req_s1;
	logic        nxt_req_s2;
	logic        nxt_req_s3;
	logic        nxt_sync_s1;
	logic        nxt_sync_s2;
	logic        nxt_sync_s3;
	logic        frame_ref_ff;
	logic        nxt_frame_ref;
	logic        mod_reset_ff;
	logic        nxt_mod_reset;
	logic        sync_done_ff;
	logic        nxt_sync_done;
	logic [7:0]  idx;
	logic        hit;
	logic [3:0]  sel;
	logic        is_status;
	logic        addr_ok;
	logic        setup;
	logic        wr_take;
	logic [15:0] status_word;
	logic        psync_on;
	logic        pins_ignored;
	logic        req_rise;
	logic        sync_go;
	logic        gen_ref;
	logic        gen_busy;
	logic        dly_busy;
	logic        dly_done;

	// ==========================================
	// Field decode
	always_comb
	begin
		psync_on     = regs_ff[S_SYNC_CTRL][`FRPCFG_PSYNC_BIT];
		// Request pin counts when phase sync is on or the mask is cleared; sync pin also needs phase sync on
		pins_ignored = regs_ff[S_PIN_MASK][`FRPCFG_MASK_BIT] & ~psync_on; // [R15]
		req_rise     = req_s2_ff & ~req_s3_ff & ~pins_ignored; // [R15]
		sync_go      = sync_s2_ff & ~sync_s3_ff & ~pins_ignored & psync_on; // [R15] [R07]
		status_word  = {13'h0000, pins_ignored, gen_busy, dly_busy};
	end

	// ==========================================
	// Address decode
	always_comb
	begin
		idx       = PADDR_I[9:2];
		hit       = 1'b0;
		sel       = 4'h0;
		for (int i = 0; i < NREG; i++)
		begin
			if (SLOT_IDX[i] == idx)
			begin
				hit = 1'b1;
				sel = 4'(i);
			end
		end
		is_status = (idx == `FRPCFG_IDX_STATUS);
		// Status is read-only; unmapped or misaligned access errors
		addr_ok   = (PADDR_I[1:0] == 2'b00) && (PADDR_I[15:10] == 6'h00)
			&& (hit || (is_status && !PWRITE_I));
	end

	// ==========================================
	// APB slave
	always_comb
	begin
		setup       = PSEL_I & ~PENABLE_I & ~pready_ff;
		wr_take     = PSEL_I & PENABLE_I & pready_ff & PWRITE_I & ~pslverr_ff;
		nxt_pready  = 1'b0;
		nxt_pslverr = 1'b0;
		nxt_prdata  = 32'h0000_0000;
		nxt_regs    = regs_ff;
		if (setup)
		begin
			nxt_pready  = 1'b1;
			nxt_pslverr = ~addr_ok;
			if (!PWRITE_I && addr_ok)
			begin
				// Plain readback, no side effect [R16]
				nxt_prdata = {16'h0000, is_status ? status_word : regs_ff[sel]};
			end
		end
		if (wr_take)
		begin
			// Full 16 bits stored, reserved fields included [R16]
			nxt_regs[sel] = PWDATA_I[15:0];
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			for (int i = 0; i < NREG; i++)
			begin
				regs_ff[i] <= SLOT_RST[i]; // [R01] [R03] [R04] [R05] [R06]
			end
		end
		else
		begin
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff  <= nxt_prdata;
			regs_ff    <= nxt_regs;
		end
	end

	// ==========================================
	// Pin synchronisers
	always_comb
	begin
		nxt_req_s1  = FRAME_REF_REQUEST_PIN_I;
		nxt_req_s2  = req_s1_ff;
		nxt_req_s3  = req_s2_ff;
		nxt_sync_s1 = SYNC_PIN_I;
		nxt_sync_s2 = sync_s1_ff;
		nxt_sync_s3 = sync_s2_ff;
	end

	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			req_s1_ff  <= 1'b0;
			req_s2_ff  <= 1'b0;
			req_s3_ff  <= 1'b0;
			sync_s1_ff <= 1'b0;
			sync_s2_ff <= 1'b0;
			sync_s3_ff <= 1'b0;
		end
		else
		begin
			req_s1_ff  <= nxt_req_s1;
			req_s2_ff  <= nxt_req_s2;
			req_s3_ff  <= nxt_req_s3;
			sync_s1_ff <= nxt_sync_s1;
			sync_s2_ff <= nxt_sync_s2;
			sync_s3_ff <= nxt_sync_s3;
		end
	end

	// ==========================================
	// Phase sync delay
	frpcfg_mod_delay u_delay
	(
		.clk_i     (CLK_I),
		.srst_i    (SRST_I),
		.start_i   (sync_go),
		.count_i   ({regs_ff[S_DLY_HI], regs_ff[S_DLY_LO]}), // [R05] [R06] [R07]
		.cal_div_i (regs_ff[S_SYNC_CTRL][`FRPCFG_CALDIV_MSB:`FRPCFG_CALDIV_LSB]),
		.busy_o    (dly_busy),
		.done_o    (dly_done)
	);

	// ==========================================
	// Frame reference generator
	frpcfg_pulse_gen u_gen
	(
		.clk_i       (CLK_I),
		.srst_i      (SRST_I),
		.enable_i    (regs_ff[S_CTRL][`FRPCFG_EN_BIT]), // [R11]
		.repeater_i  (regs_ff[S_CTRL][`FRPCFG_REPEAT_BIT]), // [R12]
		.multi_i     (regs_ff[S_CTRL][`FRPCFG_MULTI_BIT]), // [R10]
		.pre_div_i   (regs_ff[S_CTRL][`FRPCFG_PRE_MSB:`FRPCFG_PRE_LSB]), // [R09]
		.out_div_i   (regs_ff[S_OUT_DIV][`FRPCFG_DIV_MSB:0]), // [R13]
		.pulse_cnt_i (regs_ff[S_PULSE_CNT][`FRPCFG_CNT_MSB:`FRPCFG_CNT_LSB]), // [R14]
		.trig_i      (req_rise),
		.ref_o       (gen_ref),
		.busy_o      (gen_busy)
	);

	// ==========================================
	// Output registers
	always_comb
	begin
		nxt_frame_ref = gen_ref;
		nxt_mod_reset = dly_busy;
		nxt_sync_done = dly_done;
	end

	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			frame_ref_ff <= 1'b0;
			mod_reset_ff <= 1'b0;
			sync_done_ff <= 1'b0;
		end
		else
		begin
			frame_ref_ff <= nxt_frame_ref;
			mod_reset_ff <= nxt_mod_reset;
			sync_done_ff <= nxt_sync_done;
		end
	end

	assign PRDATA_O          = prdata_ff;
	assign PREADY_O          = pready_ff;
	assign PSLVERR_O         = pslverr_ff;
	assign FRAME_REF_O       = frame_ref_ff;
	assign MOD_RESET_O       = mod_reset_ff;
	assign PHASE_SYNC_DONE_O = sync_done_ff;

endmodule // frpcfg_top

// [frpcfg_params.svh]
// Purpose: Offsets, field positions, reset values of the frame reference config slice
// Assumes: Register index times four is the APB byte address
// Notes:   Definitions only
//
// Contract
// [R01] The first word resets to 0x1388 and software keeps writing 0x1388 into it.
// [R02] Software writes zero into the second and fourth reserved words.
// [R03] The third reserved word resets to 0x140 and software overwrites it with 0x1F4.
// [R04] The fifth reserved word resets to 0x3E8 and software writes 0x3E8 into it.
// [R05] Bits 31..16 of the modulator reset delay count sit in a 16-bit word reset to zero.
// [R06] Bits 15..0 of the delay count sit in the next word, reset to 0xC350.
// [R07] A phase sync inserts the programmed count of periods of 2^cal_div base clocks.
// [R08] Software should make that delay at least four times the loop lock time.
// [R09] A 3-bit pre-divider at bits 7..5, reset 0x4, divides by 2 or by 4.
// [R10] Multi-burst bit 4 in master mode sends a burst on each rising request pin.
// [R11] Master mode with the generator on at bit 3 sends pulses continuously.
// [R12] Repeater mode at bit 2 sends pulses only in answer to the request pin.
// [R13] An 11-bit output divider at bits 10..0, reset 0x1, divides the pulse rate further.
// [R14] Bits 15..12 of the neighbouring word give the number of pulses in a burst.
// [R15] With phase sync off and mask bit 15 set, sync and request pins are ignored.
// [R16] Every word is 16 bits, reads back what was written, and reads have no side effect.
// [R17] Divider and mode writes reach the generator only at a pulse boundary.
`ifndef FRPCFG_PARAMS_SVH
`define FRPCFG_PARAMS_SVH

// ==========================================
// Register indices
`define FRPCFG_IDX_RSV_A      8'h40
`define FRPCFG_IDX_RSV_B      8'h41
`define FRPCFG_IDX_RSV_C      8'h42
`define FRPCFG_IDX_RSV_D      8'h43
`define FRPCFG_IDX_RSV_E      8'h44
`define FRPCFG_IDX_DLY_HI     8'h45
`define FRPCFG_IDX_DLY_LO     8'h46
`define FRPCFG_IDX_CTRL       8'h47
`define FRPCFG_IDX_OUT_DIV    8'h48
`define FRPCFG_IDX_PULSE_CNT  8'h4A
`define FRPCFG_IDX_PIN_MASK   8'h3A
`define FRPCFG_IDX_SYNC_CTRL  8'h60
`define FRPCFG_IDX_STATUS     8'h61

// ==========================================
// Reset values
`define FRPCFG_RST_RSV_A      16'h1388
`define FRPCFG_RST_RSV_B      16'h0000
`define FRPCFG_RST_RSV_C      16'h0140
`define FRPCFG_RST_RSV_D      16'h0000
`define FRPCFG_RST_RSV_E      16'h03E8
`define FRPCFG_RST_DLY_HI     16'h0000
`define FRPCFG_RST_DLY_LO     16'hC350
`define FRPCFG_RST_CTRL       16'h0080
`define FRPCFG_RST_OUT_DIV    16'h0001
`define FRPCFG_RST_PULSE_CNT  16'h0000
`define FRPCFG_RST_PIN_MASK   16'h8001
`define FRPCFG_RST_SYNC_CTRL  16'h0000

// ==========================================
// Field positions
`define FRPCFG_PRE_MSB        7
`define FRPCFG_PRE_LSB        5
`define FRPCFG_MULTI_BIT      4
`define FRPCFG_EN_BIT         3
`define FRPCFG_REPEAT_BIT     2
`define FRPCFG_DIV_MSB        10
`define FRPCFG_CNT_MSB        15
`define FRPCFG_CNT_LSB        12
`define FRPCFG_MASK_BIT       15
`define FRPCFG_PSYNC_BIT      0
`define FRPCFG_CALDIV_MSB     4
`define FRPCFG_CALDIV_LSB     1

`endif

// [frpcfg_pkg.sv]
// Purpose: Types shared by the frame reference config slice
// Assumes: Constants live in frpcfg_params.svh
// Notes:   Types only
package frpcfg_pkg;

	// ==========================================
	// State machines
	typedef enum logic [1:0]
	{
		GEN_IDLE = 2'b00,
		GEN_HIGH = 2'b01,
		GEN_LOW  = 2'b10
	} frpcfg_gen_state_type;

	typedef enum logic
	{
		DLY_IDLE = 1'b0,
		DLY_RUN  = 1'b1
	} frpcfg_dly_state_type;

endpackage

// [frpcfg_mod_delay.sv]
// Purpose: Modulator reset delay timer for phase sync
// Assumes: Base clock stands in for the oscillator calibration clock
// Notes:   Start while running is ignored
module frpcfg_mod_delay
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        start_i,
	input  wire logic [31:0] count_i,
	input  wire logic [3:0]  cal_div_i,
	output logic             busy_o,
	output logic             done_o
);

	// ==========================================
	// Timer
	frpcfg_pkg::frpcfg_dly_state_type state_ff;
	frpcfg_pkg::frpcfg_dly_state_type nxt_state;
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic [31:0] lim_ff;
	logic [31:0] nxt_lim;
	logic [15:0] pre_ff;
	logic [15:0] nxt_pre;
	logic [15:0] pre_mask_ff;
	logic [15:0] nxt_pre_mask;
	logic        done_ff;
	logic        nxt_done;

	always_comb
	begin
		nxt_state    = state_ff;
		nxt_cnt      = cnt_ff;
		nxt_lim      = lim_ff;
		nxt_pre      = pre_ff;
		nxt_pre_mask = pre_mask_ff;
		nxt_done     = 1'b0;
		case (state_ff)
			frpcfg_pkg::DLY_IDLE:
			begin
				if (start_i)
				begin
					nxt_state    = frpcfg_pkg::DLY_RUN;
					nxt_cnt      = 32'h0000_0000;
					nxt_pre      = 16'h0000;
					nxt_lim      = count_i;
					// Period is 2^cal_div base clocks [R07]
					nxt_pre_mask = 16'((17'h0_0001 << cal_div_i) - 17'h0_0001);
				end
			end
			frpcfg_pkg::DLY_RUN:
			begin
				if (cnt_ff == lim_ff)
				begin
					nxt_state = frpcfg_pkg::DLY_IDLE;
					nxt_done  = 1'b1; // [R07]
				end
				else if (pre_ff == pre_mask_ff)
				begin
					nxt_pre = 16'h0000;
					nxt_cnt = cnt_ff + 32'h0000_0001; // [R07]
				end
				else
				begin
					nxt_pre = pre_ff + 16'h0001;
				end
			end
			default:
			begin
				nxt_state = frpcfg_pkg::DLY_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_ff    <= frpcfg_pkg::DLY_IDLE;
			cnt_ff      <= 32'h0000_0000;
			lim_ff      <= 32'h0000_0000;
			pre_ff      <= 16'h0000;
			pre_mask_ff <= 16'h0000;
			done_ff     <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			cnt_ff      <= nxt_cnt;
			lim_ff      <= nxt_lim;
			pre_ff      <= nxt_pre;
			pre_mask_ff <= nxt_pre_mask;
			done_ff     <= nxt_done;
		end
	end

	assign busy_o = (state_ff == frpcfg_pkg::DLY_RUN);
	assign done_o = done_ff;

endmodule // frpcfg_mod_delay

// [frpcfg_pulse_gen.sv]
// Purpose: Frame reference pulse generator
// Assumes: Trigger is a one-cycle pulse already synchronised
// Notes:   Half period is pre-divider times output divider base clocks
module frpcfg_pulse_gen
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        enable_i,
	input  wire logic        repeater_i,
	input  wire logic        multi_i,
	input  wire logic [2:0]  pre_div_i,
	input  wire logic [10:0] out_div_i,
	input  wire logic [3:0]  pulse_cnt_i,
	input  wire logic        trig_i,
	output logic             ref_o,
	output logic             busy_o
);

	// ==========================================
	// Generator
	frpcfg_pkg::frpcfg_gen_state_type state_ff;
	frpcfg_pkg::frpcfg_gen_state_type nxt_state;
	logic [13:0] cnt_ff;
	logic [13:0] nxt_cnt;
	logic [13:0] half_ff;
	logic [13:0] nxt_half;
	logic [3:0]  left_ff;
	logic [3:0]  nxt_left;
	logic        cont_ff;
	logic        nxt_cont;
	logic [2:0]  pre_eff;
	logic [10:0] div_eff;
	logic [13:0] half_new;
	logic        cont_now;

	always_comb
	begin
		// Zero divides act as one, so the counter never wraps
		pre_eff   = (pre_div_i == 3'h0) ? 3'h1 : pre_div_i; // [R09]
		div_eff   = (out_div_i == 11'h000) ? 11'h001 : out_div_i; // [R13]
		half_new  = 14'(pre_eff) * 14'(div_eff); // [R09] [R13]
		cont_now  = enable_i & ~repeater_i & ~multi_i; // [R11]
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_half  = half_ff;
		nxt_left  = left_ff;
		nxt_cont  = cont_ff;
		case (state_ff)
			frpcfg_pkg::GEN_IDLE:
			begin
				if (cont_now || (enable_i && trig_i && (repeater_i
					|| (multi_i && pulse_cnt_i != 4'h0)))) // [R10] [R11] [R12]
				begin
					nxt_state = frpcfg_pkg::GEN_HIGH;
					nxt_half  = half_new; // [R17]
					nxt_cnt   = half_new - 14'h0001;
					nxt_cont  = cont_now;
					nxt_left  = (repeater_i || cont_now) ? 4'h0
						: pulse_cnt_i - 4'h1; // [R14]
				end
			end
			frpcfg_pkg::GEN_HIGH:
			begin
				if (cnt_ff == 14'h0000)
				begin
					nxt_state = frpcfg_pkg::GEN_LOW;
					nxt_cnt   = half_ff - 14'h0001;
				end
				else
				begin
					nxt_cnt = cnt_ff - 14'h0001;
				end
			end
			frpcfg_pkg::GEN_LOW:
			begin
				if (cnt_ff != 14'h0000)
				begin
					nxt_cnt = cnt_ff - 14'h0001;
				end
				else if (enable_i && ((cont_ff && cont_now) || left_ff != 4'h0)) // [R10]
				begin
					// New settings only at the period boundary [R17]
					nxt_state = frpcfg_pkg::GEN_HIGH;
					nxt_half  = half_new;
					nxt_cnt   = half_new - 14'h0001;
					nxt_left  = (cont_ff && cont_now) ? 4'h0 : left_ff - 4'h1;
				end
				else
				begin
					nxt_state = frpcfg_pkg::GEN_IDLE;
					nxt_cont  = 1'b0;
				end
			end
			default:
			begin
				nxt_state = frpcfg_pkg::GEN_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_ff <= frpcfg_pkg::GEN_IDLE;
			cnt_ff   <= 14'h0000;
			half_ff  <= 14'h0001;
			left_ff  <= 4'h0;
			cont_ff  <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			half_ff  <= nxt_half;
			left_ff  <= nxt_left;
			cont_ff  <= nxt_cont;
		end
	end

	assign ref_o  = (state_ff == frpcfg_pkg::GEN_HIGH);
	assign busy_o = (state_ff != frpcfg_pkg::GEN_IDLE);

endmodule // frpcfg_pulse_gen

// [frpcfg_properties.sv]
// Purpose: Port-level timing checks for frpcfg_top
// Assumes: One wait-free access phase per transfer
// Notes:   Bound into every frpcfg_top instance
module frpcfg_props #(
	parameter int NREG = 12
)
(
	input wire logic        CLK_I,
	input wire logic        SRST_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [15:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic        FRAME_REF_REQUEST_PIN_I,
	input wire logic        SYNC_PIN_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic        FRAME_REF_O,
	input wire logic        MOD_RESET_O,
	input wire logic        PHASE_SYNC_DONE_O
);
	// ==========================================
	// Checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	wire logic setup = PSEL_I && !PENABLE_I;
	wire logic bad_a = (PADDR_I[1:0] != 2'b00) || (PADDR_I[15:10] != 6'h00);
	a_ready_next: assert property (setup |=> PREADY_O)
		else $error("ready missing after setup");
	a_ready_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
		else $error("ready outside access phase");
	a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	a_upper_zero: assert property (PREADY_O |-> PRDATA_O[31:16] == 16'h0000)
		else $error("upper read lanes not zero");
	a_write_nodata: assert property (PREADY_O && PWRITE_I |-> PRDATA_O == 32'h0000_0000)
		else $error("read data on write");
	a_bad_addr: assert property (setup && bad_a |=> PSLVERR_O)
		else $error("bad address accepted");
	a_map_ok: assert property (setup && !bad_a && PADDR_I[9:2] inside {[8'h40:8'h48]}
		|=> !PSLVERR_O)
		else $error("mapped word refused");
	a_done_single: assert property (PHASE_SYNC_DONE_O |=> !PHASE_SYNC_DONE_O)
		else $error("done longer than one cycle");
	a_done_after: assert property ($fell(MOD_RESET_O) |-> ##[0:2] PHASE_SYNC_DONE_O)
		else $error("no done after delay");
endmodule // frpcfg_props

bind frpcfg_top frpcfg_props #(.NREG(NREG)) u_frpcfg_props
(
	.CLK_I(CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
	.FRAME_REF_REQUEST_PIN_I(FRAME_REF_REQUEST_PIN_I), .SYNC_PIN_I(SYNC_PIN_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.FRAME_REF_O(FRAME_REF_O), .MOD_RESET_O(MOD_RESET_O),
	.PHASE_SYNC_DONE_O(PHASE_SYNC_DONE_O)
);

// [frpcfg_top_tb.sv]
// Purpose: Self-checking bench for frpcfg_top
// Assumes: Slave answers in first access cycle, bench still waits on ready
// Notes:   Small delay count keeps phase sync runs short
module frpcfg_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Signals
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        req = 1'b0;
	logic        sync = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, fref, modrst, pdone;
	logic [31:0] rd;
	logic        er;
	int          err_count = 0;
	int          n_checks = 0;
	int          n, h, d, k;
	frpcfg_top u_frpcfg_top (.CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .FRAME_REF_REQUEST_PIN_I(req),
		.SYNC_PIN_I(sync), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.FRAME_REF_O(fref), .MOD_RESET_O(modrst), .PHASE_SYNC_DONE_O(pdone));
	initial forever #25 clk = ~clk;
	// ==========================================
	// Helpers
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task chk_rng(input string what, input int lo, input int hi, input int got);
		n_checks++;
		if (got < lo || got > hi)
		begin
			err_count++;
			$display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
		end
	endtask
	// Request held until ready is sampled high
	task apb(input logic w, input logic [15:0] a, input logic [15:0] wd);
		int t;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, wd};
		@(posedge clk);
		penable <= 1'b1;
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			err_count++;
			summarize();
		end
	endtask
	task wr(input logic [7:0] i, input logic [15:0] v);
		apb(1'b1, {6'h00, i, 2'b00}, v);
		chk("write err", 32'h0000_0000, {31'h0000_0000, er});
	endtask
	task rdc(input logic [7:0] i, input logic [15:0] v);
		apb(1'b0, {6'h00, i, 2'b00}, 16'h0000);
		chk("read data", {16'h0000, v}, rd);
		chk("read err", 32'h0000_0000, {31'h0000_0000, er});
	endtask
	task hi_len(output int hl);
		int t;
		t = 0;
		while (fref !== 1'b0 && t < 2000) begin @(posedge clk); t++; end
		while (fref !== 1'b1 && t < 2000) begin @(posedge clk); t++; end
		hl = 0;
		while (fref === 1'b1 && hl < 400) begin hl++; @(posedge clk); end
		if (t >= 2000 || hl >= 400)
		begin
			err_count++;
			summarize();
		end
	endtask
	task cnt_rise(input int cyc, output int nr);
		logic prev;
		prev = fref;
		nr = 0;
		repeat (cyc)
		begin
			@(posedge clk);
			nr += (fref === 1'b1 && prev !== 1'b1);
			prev = fref;
		end
	endtask
	// Two cycles wide so the synchroniser sees it
	task pin_req;
		req <= 1'b1;
		repeat (2) @(posedge clk);
		req <= 1'b0;
	endtask
	// ==========================================
	// Scenarios
	logic [7:0]  ri[12] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48,
		8'h4A, 8'h3A, 8'h60};
	logic [15:0] rv[12] = '{16'h1388, 16'h0000, 16'h0140, 16'h0000, 16'h03E8, 16'h0000,
		16'hC350, 16'h0080, 16'h0001, 16'h0000, 16'h8001, 16'h0000};
	logic [15:0] wv[9] = '{16'h1388, 16'h0000, 16'h01F4, 16'h0000, 16'h03E8, 16'hA5A5,
		16'h5A5A, 16'hFF03, 16'h07FF};
	logic [15:0] ba[4] = '{16'h0101, 16'h0500, 16'h0140, 16'h0184};
	task t_regs;
		for (int i = 0; i < 12; i++) rdc(ri[i], rv[i]);
		for (int i = 0; i < 9; i++) wr(ri[i], wv[i]);
		for (int i = 0; i < 9; i++) rdc(ri[i], wv[i]);
		for (int i = 0; i < 4; i++)
		begin
			apb(i[0], ba[i], 16'h1234);
			chk("refused err", 32'h0000_0001, {31'h0000_0000, er});
			chk("refused data", 32'h0000_0000, rd);
		end
		rdc(8'h61, 16'h0004);
		rdc(8'h47, 16'hFF03);
		wr(8'h47, 16'h0000);
		$display("test regs done");
	endtask
	task t_cont;
		wr(8'h48, 16'h0001);
		wr(8'h47, 16'h0088);
		hi_len(h);
		hi_len(h);
		chk_rng("high pre4", 4, 4, h);
		wr(8'h47, 16'h0048);
		hi_len(h);
		hi_len(h);
		chk_rng("high pre2", 2, 2, h);
		wr(8'h48, 16'h0003);
		hi_len(h);
		hi_len(h);
		chk_rng("high div3", 6, 6, h);
		wr(8'h47, 16'h0000);
		repeat (30) @(posedge clk);
		cnt_rise(60, n);
		chk_rng("off pulses", 0, 0, n);
		$display("test continuous done");
	endtask
	task t_pins;
		wr(8'h48, 16'h0001);
		wr(8'h47, 16'h008C);
		pin_req();
		cnt_rise(60, n);
		chk_rng("masked pulses", 0, 0, n);
		wr(8'h3A, 16'h0001);
		cnt_rise(60, n);
		chk_rng("idle repeater", 0, 0, n);
		pin_req();
		cnt_rise(60, n);
		chk_rng("repeater pulses", 1, 1, n);
		wr(8'h4A, 16'h3000);
		wr(8'h47, 16'h0098);
		cnt_rise(40, n);
		chk_rng("idle burst", 0, 0, n);
		pin_req();
		cnt_rise(80, n);
		chk_rng("burst of 3", 3, 3, n);
		wr(8'h4A, 16'hF000);
		pin_req();
		cnt_rise(200, n);
		chk_rng("burst of 15", 15, 15, n);
		wr(8'h47, 16'h0000);
		$display("test pins done");
	endtask
	task t_sync;
		wr(8'h45, 16'h0000);
		wr(8'h46, 16'h0003); // Short count, no lock time modelled
		for (int c = 0; c < 2; c++)
		begin
			wr(8'h60, {11'h000, c[3:0], 1'b1});
			sync <= 1'b1;
			k = 0;
			while (modrst !== 1'b1 && k < 50) begin @(posedge clk); k++; end
			if (k >= 50)
			begin
				err_count++;
				summarize();
			end
			sync <= 1'b0;
			h = 0;
			d = 0;
			while (modrst === 1'b1 && h < 100) begin h++; @(posedge clk); d += pdone; end
			repeat (3) begin @(posedge clk); d += (pdone === 1'b1); end
			chk_rng("delay length", 3 * (1 << c), 3 * (1 << c) + 2, h);
			chk_rng("done pulses", 1, 1, d);
		end
		$display("test sync done");
	endtask
	// ==========================================
	// Sequence
	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_cont();
		t_pins();
		t_sync();
		summarize();
	end
endmodule // frpcfg_top_tb
